/* hdl/sercfg_i2c.sv */
/*
 * Serial control bus slave: address match, register pointer,
 * auto-incrementing writes and reads.
 * Assumes scl and sda already pass two flip-flops in the caller.
 */
`timescale 1ns/100ps
module sercfg_i2c
  import sercfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus side
  input wire logic enable,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [6:0] own_addr,
  output logic sda_oe,
  // Register side
  output logic wr_stb,
  output logic [7:0] wr_idx,
  output logic [7:0] wr_data,
  output logic [7:0] rd_idx,
  input wire logic [7:0] rd_data
);

  sercfg_i2c_e state_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic first_q;
  logic nack_q;
  logic [7:0] ptr_q;
  logic oe_q;
  logic stb_q;
  logic [7:0] widx_q;
  logic [7:0] wdat_q;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire byte_done = cnt_q == 4'h8;

  assign sda_oe = oe_q;
  assign wr_stb = stb_q;
  assign wr_idx = widx_q;
  assign wr_data = wdat_q;
  assign rd_idx = ptr_q;

  always_ff @(posedge clk)
  begin
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
    stb_q <= 1'b0;
    if (sys_rst || !enable)
    begin
      state_q <= ST_IDLE;
      oe_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b1;
      nack_q <= 1'b1;
      ptr_q <= 8'h00;
      widx_q <= 8'h00;
      wdat_q <= 8'h00;
    end
    else if (start_c)
    begin
      state_q <= ST_ADDR;
      oe_q <= 1'b0;
      cnt_q <= 4'h0;
      first_q <= 1'b1;
    end
    else if (stop_c)
    begin
      state_q <= ST_IDLE;
      oe_q <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_q == ST_ADDR || state_q == ST_RX)
      begin
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
      if (state_q == ST_TACK)
        nack_q <= sda_s;
    end
    else if (scl_fall)
    begin
      case (state_q)
        ST_ADDR:
          if (byte_done)
          begin
            // Only a matching address is acknowledged
            state_q <= (sh_q[7:1] == own_addr) ? ST_AACK : ST_IDLE;
            oe_q <= sh_q[7:1] == own_addr;
            rw_q <= sh_q[0];
          end
        ST_AACK:
        begin
          cnt_q <= 4'h0;
          tx_q <= rd_data;
          state_q <= rw_q ? ST_TX : ST_RX;
          oe_q <= rw_q & ~rd_data[7];
        end
        ST_RX:
          if (byte_done)
          begin
            // First byte after the address sets the pointer
            if (first_q)
              ptr_q <= sh_q;
            else
            begin
              stb_q <= 1'b1;
              widx_q <= ptr_q;
              wdat_q <= sh_q;
              ptr_q <= ptr_q + 8'h01;
            end
            first_q <= 1'b0;
            oe_q <= 1'b1;
            state_q <= ST_RACK;
          end
        ST_RACK:
        begin
          oe_q <= 1'b0;
          cnt_q <= 4'h0;
          state_q <= ST_RX;
        end
        ST_TX:
          if (cnt_q == 4'h7)
          begin
            oe_q <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
            state_q <= ST_TACK;
          end
          else
          begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
            cnt_q <= cnt_q + 4'h1;
          end
        ST_TACK:
          if (nack_q)
            state_q <= ST_IDLE;
          else
          begin
            tx_q <= rd_data;
            oe_q <= ~rd_data[7];
            cnt_q <= 4'h0;
            state_q <= ST_TX;
          end
        default:
        begin
          state_q <= ST_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* hdl/sercfg_pkg.sv */
/*
 * Constants and types of the serializer configuration register bank.
 * Assumes a 100 MHz system clock.
 */
package sercfg_pkg;

  // ****************************************
  // Register indexes and reset values
  // ****************************************
  localparam logic [7:0] REG_CONFIG_IDX = 8'h00;
  localparam logic [7:0] REG_ADDRSEL_IDX = 8'h01;
  localparam logic [7:0] REG_EMPH_IDX = 8'h02;
  localparam logic [7:0] REG_CONFIG_RST = 8'h00;
  localparam logic [7:0] REG_ADDRSEL_RST = 8'h68;
  localparam logic [7:0] REG_EMPH_RST = 8'h00;
  localparam logic [7:0] REG_CONFIG_PINS = 8'h01;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_SLEEP_BIT = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_EDGE_BIT = 4;
  localparam int CFG_SWING_BIT = 5;
  localparam int ADDR_SRC_BIT = 7;
  localparam int EMPH_LVL_LSB = 5;
  localparam int EMPH_DIS_BIT = 4;

  // ****************************************
  // Valid bus addresses, strap codes 0..3
  // ****************************************
  localparam logic [6:0] BUS_ADDR_0 = 7'h69;
  localparam logic [6:0] BUS_ADDR_1 = 7'h6a;
  localparam logic [6:0] BUS_ADDR_2 = 7'h6b;
  localparam logic [6:0] BUS_ADDR_3 = 7'h6e;
  localparam logic [2:0] EMPH_EXTERNAL = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100000000;
  localparam int POWERUP_MS = 10;
  localparam int POWERUP_CYCLES = POWERUP_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0]
  {
    MODE_FILTER_OFF = 2'h0,
    MODE_FILTER_ON = 2'h1,
    MODE_LEGACY_A = 2'h2,
    MODE_LEGACY_B = 2'h3
  } sercfg_mode_e;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX = 3'h2,
    ST_RACK = 3'h6,
    ST_TX = 3'h7,
    ST_TACK = 3'h5
  } sercfg_i2c_e;

  typedef struct packed
  {
    sercfg_mode_e filter_mode;
    logic sleep;
    logic pixel_edge_select;
    logic output_swing_select;
    logic [2:0] emphasis_level;
    logic emphasis_on;
  } sercfg_cfg_s;

endpackage

/* hdl/sercfg_regs.sv */
/*
 * Serializer configuration register bank behind the serial control bus,
 * with pin/register source selection of the effective configuration.
 * Assumes all pins are asynchronous to clk and the bus runs far below it.
 */
`timescale 1ns/100ps
// Operation
// - Config bit 0: clear uses pins, set uses registers; address has own source
// - Config bit 1 sets sleep, registers kept; separate from powerdown pin
// - Config bits 3:2: filter off, filter on, two legacy modes
// - Config bit 4 picks pixel capture edge: 0 falling, 1 rising
// - Address register bit 7: 0 strap pin address, 1 register address
// - Address bits 6:0 hold address; only 69h, 6Ah, 6Bh, 6Eh valid
// - Emphasis bits 7:5: 000 external resistor, others fixed -1 to -12 dB
// - Emphasis bit 4 inverted: 0 applies de-emphasis, 1 disables it
// - Config resets to 00h; host writes 01h for register control
// - No bus response until 10 ms after power-up
module sercfg_regs
  import sercfg_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial control bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Control and strap pins
  input wire logic powerdown_pin,
  input wire logic [1:0] pin_filter_mode,
  input wire logic pin_edge,
  input wire logic pin_swing,
  input wire logic [1:0] bus_address_strap,
  // Effective configuration
  output sercfg_cfg_s cfg,
  output logic powered_down,
  output logic [6:0] bus_address_value,
  output logic bus_ready
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync_q;
  wire [NSYNC-1:0] pins_raw = {scl_in, sda_in, powerdown_pin,
    pin_filter_mode, pin_edge, pin_swing, bus_address_strap};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        sync1_q[g] <= pins_raw[g];
        sync_q[g] <= sync1_q[g];
      end
    end
  endgenerate

  wire scl_s = sync_q[8];
  wire sda_s = sync_q[7];
  wire pdn_s = sync_q[6];
  wire [1:0] mode_s = sync_q[5:4];
  wire edge_s = sync_q[3];
  wire swing_s = sync_q[2];
  wire [1:0] strap_s = sync_q[1:0];

  function automatic logic addr_ok(input logic [6:0] a);
    addr_ok = (a == BUS_ADDR_0) || (a == BUS_ADDR_1) ||
              (a == BUS_ADDR_2) || (a == BUS_ADDR_3);
  endfunction

  function automatic logic [6:0] strap_addr(input logic [1:0] c);
    case (c)
      2'h0: strap_addr = BUS_ADDR_0;
      2'h1: strap_addr = BUS_ADDR_1;
      2'h2: strap_addr = BUS_ADDR_2;
      default: strap_addr = BUS_ADDR_3;
    endcase
  endfunction

  // ****************************************
  // Power-up hold-off
  // ****************************************
  logic [31:0] wait_q;
  logic ready_q;
  logic strap_take_q;
  logic [6:0] strap_addr_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_q <= 32'h0;
      ready_q <= 1'b0;
      strap_take_q <= 1'b1;
      strap_addr_q <= BUS_ADDR_0;
    end
    else
    begin
      if (!ready_q)
        wait_q <= wait_q + 32'h1;
      if (wait_q == 32'(POWERUP_WAIT - 1))
        ready_q <= 1'b1;
      // Strap caught once, after sync settles
      if (strap_take_q && wait_q == 32'h2)
      begin
        strap_addr_q <= strap_addr(strap_s);
        strap_take_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bus slave and register file
  // ****************************************
  logic wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic [7:0] reg0_q;
  logic [7:0] reg1_q;
  logic [7:0] reg2_q;
  logic oe_w;
  logic sda_out_q;
  logic sda_oe_q;

  sercfg_i2c u_bus
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(ready_q),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .own_addr(bus_address_value),
    .sda_oe(oe_w),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  wire wr0 = wr_stb && wr_idx == REG_CONFIG_IDX;
  wire wr1 = wr_stb && wr_idx == REG_ADDRSEL_IDX;
  wire wr2 = wr_stb && wr_idx == REG_EMPH_IDX;
  // Unmapped indexes read zero
  assign rd_data = (rd_idx == REG_CONFIG_IDX) ? reg0_q :
                   (rd_idx == REG_ADDRSEL_IDX) ? reg1_q :
                   (rd_idx == REG_EMPH_IDX) ? reg2_q : 8'h00;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg0_q <= REG_CONFIG_RST;
      reg1_q <= REG_ADDRSEL_RST;
      reg2_q <= REG_EMPH_RST;
    end
    else
    begin
      // Whole bytes stored, reserved bits included
      if (wr0)
        reg0_q <= wr_data;
      if (wr1)
        reg1_q <= wr_data;
      if (wr2)
        reg2_q <= wr_data;
    end
  end

  // ****************************************
  // Effective configuration
  // ****************************************
  sercfg_cfg_s cfg_d;
  sercfg_cfg_s cfg_q;
  logic [6:0] addr_d;
  logic [6:0] addr_q;
  logic pdn_q;

  wire use_regs = reg0_q[CFG_SRC_BIT];
  wire addr_from_reg = reg1_q[ADDR_SRC_BIT];
  wire [6:0] addr_field = reg1_q[6:0];

  always_comb
  begin
    cfg_d.filter_mode = sercfg_mode_e'(use_regs ? reg0_q[CFG_MODE_LSB +: 2] : mode_s);
    cfg_d.sleep = reg0_q[CFG_SLEEP_BIT];
    cfg_d.pixel_edge_select = use_regs ? reg0_q[CFG_EDGE_BIT] : edge_s;
    cfg_d.output_swing_select = use_regs ? reg0_q[CFG_SWING_BIT] : swing_s;
    cfg_d.emphasis_level = use_regs ? reg2_q[EMPH_LVL_LSB +: 3] : EMPH_EXTERNAL;
    cfg_d.emphasis_on = use_regs ? ~reg2_q[EMPH_DIS_BIT] : 1'b1;
    // Reserved register address falls back to strap
    addr_d = (addr_from_reg && addr_ok(addr_field)) ? addr_field : strap_addr_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_q <= '0;
      addr_q <= BUS_ADDR_0;
      pdn_q <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      addr_q <= addr_d;
      pdn_q <= pdn_s;
      sda_out_q <= 1'b0;
      sda_oe_q <= oe_w;
    end
  end

  assign cfg = cfg_q;
  assign bus_address_value = addr_q;
  assign powered_down = pdn_q;
  assign bus_ready = ready_q;
  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_src_pins: assert property (!use_regs |=> cfg_q.filter_mode == $past(mode_s))
    else $error("pin mode not followed");
  a_src_regs: assert property (use_regs |=> cfg_q.filter_mode == $past(reg0_q[3:2]))
    else $error("register mode not followed");
  a_sleep_follow: assert property (reg0_q[1] |=> cfg_q.sleep)
    else $error("sleep not applied");
  a_sleep_keep: assert property ($rose(reg0_q[1]) |-> $stable(reg1_q) && $stable(reg2_q))
    else $error("sleep disturbed registers");
  a_edge_sel: assert property (use_regs |=> cfg_q.pixel_edge_select == $past(reg0_q[4]))
    else $error("capture edge wrong");
  a_addr_src: assert property (addr_from_reg && addr_ok(addr_field) |=> addr_q == $past(addr_field))
    else $error("register address not used");
  a_addr_valid: assert property (addr_ok(addr_q))
    else $error("reserved bus address in use");
  a_emph_level: assert property (use_regs |=> cfg_q.emphasis_level == $past(reg2_q[7:5]))
    else $error("emphasis level wrong");
  a_emph_inv: assert property (use_regs |=> cfg_q.emphasis_on == !$past(reg2_q[4]))
    else $error("emphasis polarity wrong");
  a_reset_vals: assert property ($fell(sys_rst) |-> reg0_q == REG_CONFIG_RST && reg1_q == REG_ADDRSEL_RST)
    else $error("reset value wrong");
  a_quiet_boot: assert property (!ready_q |=> !sda_oe_q)
    else $error("bus answered before power-up delay");

endmodule

/* tb/sercfg_host.sv */
/*
 * Host model of the serial control bus: START, STOP, byte write and read.
 * Assumes SCL and SDA are open drain with pull-ups resolved by the caller.
 */
`timescale 1ns/100ps
module sercfg_host
  import sercfg_pkg::*;
#(
  parameter int HALF = 6,
  parameter int WAIT_UP = 20
)
(
  // Clock
  input wire logic clk,
  // Bus wires
  input wire logic sda_w,
  output logic scl_o,
  output logic sda_lo
);
  // ****************************************
  // Bus phases
  // ****************************************
  initial
  begin
    scl_o = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic hp();
    repeat (HALF) @(negedge clk);
  endtask
  task automatic powerup_wait();
    repeat (WAIT_UP) @(negedge clk);
  endtask
  task automatic start();
    sda_lo = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_lo = 1'b1;
    hp();
    scl_o = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_lo = 1'b0;
    hp();
  endtask
  task automatic bitx(input logic lo, output logic seen);
    sda_lo = lo;
    hp();
    scl_o = 1'b1;
    hp();
    seen = sda_w;
    scl_o = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(~b[i], s);
    bitx(1'b0, s);
    ack = ~s;
  endtask
  task automatic byte_r(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b0, b[i]);
    bitx(~last, s);
  endtask
  // Index then up to three data bytes, auto-increment in the slave
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [23:0] d, input int n,
    output logic ok);
    logic k;
    start();
    byte_w({a, 1'b0}, ok);
    byte_w(idx, k);
    ok = ok & k;
    for (int j = 0; j < n; j++)
    begin
      byte_w(d[23:16], k);
      ok = ok & k;
      d = d << 8;
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] v, output logic ok);
    logic k;
    start();
    byte_w({a, 1'b0}, ok);
    byte_w(idx, k);
    ok = ok & k;
    start();
    byte_w({a, 1'b1}, k);
    ok = ok & k;
    byte_r(1'b1, v);
    stop();
  endtask
endmodule

/* tb/tb.sv */
/*
 * Self-checking bench of the serializer configuration register bank.
 * Assumes the host model and pull-ups on both bus wires.
 */
`timescale 1ns/100ps
module tb
  import sercfg_pkg::*;
;
  localparam int PUW = 2000;
  logic clk, sys_rst, scl, host_lo, sda_out, sda_oe, powerdown_pin, pin_edge, pin_swing;
  logic powered_down, bus_ready, ok;
  logic [1:0] pin_filter_mode, bus_address_strap;
  logic [6:0] bus_address_value, cur;
  logic [7:0] v;
  sercfg_cfg_s cfg;
  wire sda_w = ~(host_lo | sda_oe);
  int error_cnt = 0;
  int n_compared = 0;
  logic [25:0] rows [0:8] = '{{8'h01, 8'h00, 10'h001}, {8'h05, 8'h20, 10'h083}, {8'h09, 8'hf0, 10'h10e},
    {8'h0d, 8'h50, 10'h184}, {8'h13, 8'h60, 10'h067}, {8'h23, 8'h80, 10'h059}, {8'hc1, 8'haf, 10'h00b},
    {8'h01, 8'hc0, 10'h00d}, {8'h02, 8'h20, 10'h161}};
  logic [14:0] arows [0:5] = '{{8'hee, 7'h6e}, {8'he9, 7'h69}, {8'heb, 7'h6b}, {8'hea, 7'h6a},
    {8'hf0, 7'h6a}, {8'h6e, 7'h6a}};
  logic [7:0] rstv [0:2] = '{8'h00, 8'h68, 8'h00};

  sercfg_regs #(.POWERUP_WAIT(PUW)) sercfg_regs_inst (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .powerdown_pin(powerdown_pin),
    .pin_filter_mode(pin_filter_mode), .pin_edge(pin_edge), .pin_swing(pin_swing),
    .bus_address_strap(bus_address_strap), .cfg(cfg), .powered_down(powered_down),
    .bus_address_value(bus_address_value), .bus_ready(bus_ready));
  sercfg_host #(.WAIT_UP(PUW)) sercfg_host_inst (.clk(clk), .sda_w(sda_w), .scl_o(scl), .sda_lo(host_lo));

  // ****************************************
  // Checking and closing
  // ****************************************
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(negedge clk);
    error_cnt++;
    report_and_stop();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    powerdown_pin = 1'b0;
    pin_filter_mode = 2'h2;
    pin_edge = 1'b1;
    pin_swing = 1'b0;
    bus_address_strap = 2'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk);
    chk(cfg, 10'h121);
    chk(bus_address_value, 7'h6a);
    chk(bus_ready, 1'b0);
    sercfg_host_inst.wr(7'h6a, 8'h00, 24'h010000, 1, ok);
    chk(ok, 1'b0);
    chk(cfg, 10'h121);
    sercfg_host_inst.powerup_wait();
    chk({sda_out, bus_ready}, 2'h1);
    for (int i = 0; i < 3; i++)
    begin
      sercfg_host_inst.rd(7'h6a, i[7:0], v, ok);
      chk(v, rstv[i]);
    end
    // Register rows: config, emphasis, expected configuration
    for (int i = 0; i < 9; i++)
    begin
      sercfg_host_inst.wr(7'h6a, 8'h00, {rows[i][25:18], 8'h68, rows[i][17:10]}, 3, ok);
      chk(ok, 1'b1);
      repeat (8) @(negedge clk);
      chk(cfg, rows[i][9:0]);
      sercfg_host_inst.rd(7'h6a, 8'h00, v, ok);
      chk(v, rows[i][25:18]);
      sercfg_host_inst.rd(7'h6a, 8'h02, v, ok);
      chk(v, rows[i][17:10]);
    end
    cur = 7'h6a;
    for (int i = 0; i < 6; i++)
    begin
      sercfg_host_inst.wr(cur, 8'h01, {arows[i][14:7], 16'h0000}, 1, ok);
      repeat (8) @(negedge clk);
      chk(bus_address_value, arows[i][6:0]);
      cur = arows[i][6:0];
      sercfg_host_inst.rd(cur, 8'h01, v, ok);
      chk({ok, v}, {1'b1, arows[i][14:7]});
    end
    sercfg_host_inst.rd(7'h6e, 8'h00, v, ok);
    chk(ok, 1'b0);
    sercfg_host_inst.wr(7'h6a, 8'h05, 24'haa0000, 1, ok);
    sercfg_host_inst.rd(7'h6a, 8'h05, v, ok);
    chk({ok, v}, 9'h100);
    @(negedge clk);
    powerdown_pin = 1'b1;
    pin_edge = 1'b0;
    pin_swing = 1'b1;
    repeat (6) @(negedge clk);
    chk({powered_down, cfg}, 10'h351);
    powerdown_pin = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(bus_ready, 1'b0);
    repeat (5) @(negedge clk);
    chk(cfg, 10'h111);
    chk(powered_down, 1'b0);
    sercfg_host_inst.powerup_wait();
    sercfg_host_inst.rd(7'h6a, 8'h00, v, ok);
    chk(v, 8'h00);
    sercfg_host_inst.rd(7'h6a, 8'h01, v, ok);
    chk(v, 8'h68);
    report_and_stop();
  end
endmodule
